/* include/tmr_pkg.sv */
// Package with register map, field positions and carriers for the system timers
package tmr_pkg;

  // ----------------------------------------------------------------
  // Register offsets on the special function register port
  // ----------------------------------------------------------------
  localparam logic [7:0] TIMER0_COUNT_LOW_ADDR   = 8'h8a; // Timer 0 low byte
  localparam logic [7:0] TIMER1_COUNT_LOW_ADDR   = 8'h8b; // Timer 1 low byte
  localparam logic [7:0] TIMER0_COUNT_HIGH_ADDR  = 8'h8c; // Timer 0 high byte
  localparam logic [7:0] TIMER1_COUNT_HIGH_ADDR  = 8'h8d; // Timer 1 high byte
  localparam logic [7:0] TIMER4_COUNT_LOW_ADDR   = 8'hac; // Timer 4 low byte
  localparam logic [7:0] TIMER4_COUNT_HIGH_ADDR  = 8'had; // Timer 4 high byte
  localparam logic [7:0] TIMER3_COUNT_LOW_ADDR   = 8'hae; // Timer 3 low byte
  localparam logic [7:0] TIMER3_COUNT_HIGH_ADDR  = 8'haf; // Timer 3 high byte
  localparam logic [7:0] TIMER2_CONTROL_ADDR     = 8'hc8; // Timer 2 control
  localparam logic [7:0] TIMER2_RELOAD_LOW_ADDR  = 8'hca; // Timer 2 reload/capture low
  localparam logic [7:0] TIMER2_RELOAD_HIGH_ADDR = 8'hcb; // Timer 2 reload/capture high
  localparam logic [7:0] TIMER2_COUNT_LOW_ADDR   = 8'hcc; // Timer 2 low byte
  localparam logic [7:0] TIMER2_COUNT_HIGH_ADDR  = 8'hcd; // Timer 2 high byte
  localparam logic [7:0] TIMER3_4_CONTROL_ADDR   = 8'hcf; // Timers 3/4 control

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  BYTE_RESET  = 8'h00; // All byte registers
  localparam logic [15:0] WORD_RESET  = 16'h0000; // 16-bit counters and reloads
  localparam logic [7:0]  READ_UNMAPPED = 8'h00; // Answer to an unmapped read

  // ----------------------------------------------------------------
  // Timer 2 control fields
  // ----------------------------------------------------------------
  localparam int T2_OVERFLOW_FLAG_BIT  = 7;
  localparam int T2_EDGE_FLAG_BIT      = 6;
  localparam int RX_CLOCK_SELECT_BIT   = 5;
  localparam int TX_CLOCK_SELECT_BIT   = 4;
  localparam int T2_TRIGGER_ENABLE_BIT = 3;
  localparam int T2_RUN_BIT            = 2;
  localparam int T2_COUNTER_SELECT_BIT = 1;
  localparam int T2_CAPTURE_SELECT_BIT = 0;

  // ----------------------------------------------------------------
  // Timers 3/4 control fields: timer n uses base 4*(n-3)
  // ----------------------------------------------------------------
  localparam int T34_IRQ_ENABLE_OFS  = 0;
  localparam int T34_RUN_OFS         = 1;
  localparam int T34_RELOAD_MODE_OFS = 2;
  localparam int T34_OVERFLOW_OFS    = 3;
  localparam int T34_FIELD_STRIDE    = 4;

  // ----------------------------------------------------------------
  // Prescale counts in system clock periods
  // ----------------------------------------------------------------
  localparam logic [3:0] T01_TIMER_DIV  = 4'hc; // Timers 0/1 timer mode
  localparam logic [3:0] T2_TIMER_DIV   = 4'hc; // Timer 2 reload/capture timer
  localparam logic [3:0] T2_BAUD_DIV    = 4'h2; // Timer 2 baud generator

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;    // Write strobe, one cycle
    logic       rd;    // Read strobe, one cycle
    logic [7:0] addr;  // Register offset
    logic [7:0] wdata; // Write data
  } tmr_sfr_req_s;

  typedef struct packed {
    logic t0_run;            // Timer 0 run control
    logic t1_run;            // Timer 1 run control
    logic t0_split;          // Timer 0 split into two 8-bit counters
    logic t0_counter_select; // Timer 0 counts pin edges
    logic t1_counter_select; // Timer 1 counts pin edges
  } tmr_t01_ctrl_s;

endpackage

/* rtl/tmr_system_timers.sv */
// System timers 0 to 4 with special function register port
`timescale 1ns/1ps

module tmr_system_timers
(
  input  wire logic                   mclk,              // System clock
  input  wire logic                   nrst,              // Synchronous reset, active low
  input  wire tmr_pkg::tmr_sfr_req_s  sfr_req,           // Register access request
  output logic [7:0]                  sfr_rdata,         // Read data, one cycle after rd
  input  wire tmr_pkg::tmr_t01_ctrl_s t01_ctrl,          // Timers 0/1 run and mode
  input  wire logic                   t0_count_pin,      // Timer 0 event pin
  input  wire logic                   t1_count_pin,      // Timer 1 event pin
  input  wire logic                   t2_count_pin,      // Timer 2 event and trigger pin
  output logic                        t0_overflow,       // Timer 0 flag set pulse
  output logic                        t1_overflow,       // Timer 1 flag set pulse
  output logic                        rx_clock_pulse,    // Serial receiver clock pulse
  output logic                        tx_clock_pulse,    // Serial transmitter clock pulse
  output logic                        t2_irq,            // Timer 2 request level
  output logic                        t3_irq,            // Timer 3 request level
  output logic                        t4_irq             // Timer 4 request level
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Replace one byte of a 16-bit word
  function automatic logic [15:0] merge_byte(input logic [15:0] word, input logic high, input logic [7:0] data);
    logic [15:0] res;
    res = word;
    if (high)
    begin
      res[15:8] = data;
    end
    else
    begin
      res[7:0] = data;
    end
    return res;
  endfunction

  // Falling edge from previous and current samples
  function automatic logic fall(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [2:0] pin_meta_reg;  // First stage, read only by second stage
  logic [2:0] pin_sync_reg;  // Second stage, safe to use
  logic [2:0] pin_prev_reg;  // Previous synchronised sample
  wire  [2:0] pin_raw;       // Raw pins: 0 timer0, 1 timer1, 2 timer2
  wire        t0_pin_fall;   // Timer 0 pin falling edge pulse
  wire        t1_pin_fall;   // Timer 1 pin falling edge pulse
  wire        t2_pin_fall;   // Timer 2 pin falling edge pulse

  assign pin_raw     = {t2_count_pin, t1_count_pin, t0_count_pin};
  assign t0_pin_fall = fall(pin_prev_reg[0], pin_sync_reg[0]);
  assign t1_pin_fall = fall(pin_prev_reg[1], pin_sync_reg[1]);
  assign t2_pin_fall = fall(pin_prev_reg[2], pin_sync_reg[2]);

  // Two-flop sync plus one sample of history, every clock
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      pin_meta_reg <= 3'h7;
      pin_sync_reg <= 3'h7;
      pin_prev_reg <= 3'h7;
    end
    else
    begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire wr_tl0  = sfr_req.wr && (sfr_req.addr == tmr_pkg::TIMER0_COUNT_LOW_ADDR);
  wire wr_tl1  = sfr_req.wr && (sfr_req.addr == tmr_pkg::TIMER1_COUNT_LOW_ADDR);
  wire wr_th0  = sfr_req.wr && (sfr_req.addr == tmr_pkg::TIMER0_COUNT_HIGH_ADDR);
  wire wr_th1  = sfr_req.wr && (sfr_req.addr == tmr_pkg::TIMER1_COUNT_HIGH_ADDR);
  wire wr_t2c  = sfr_req.wr && (sfr_req.addr == tmr_pkg::TIMER2_CONTROL_ADDR);
  wire wr_timer2_reload_low = sfr_req.wr && (sfr_req.addr == tmr_pkg::TIMER2_RELOAD_LOW_ADDR);
  wire wr_timer2_reload_high = sfr_req.wr && (sfr_req.addr == tmr_pkg::TIMER2_RELOAD_HIGH_ADDR);
  wire wr_t2l  = sfr_req.wr && (sfr_req.addr == tmr_pkg::TIMER2_COUNT_LOW_ADDR);
  wire wr_t2h  = sfr_req.wr && (sfr_req.addr == tmr_pkg::TIMER2_COUNT_HIGH_ADDR);
  wire wr_t34c = sfr_req.wr && (sfr_req.addr == tmr_pkg::TIMER3_4_CONTROL_ADDR);
  wire [1:0] wr_t34l; // Timer 3/4 low byte writes
  wire [1:0] wr_t34h; // Timer 3/4 high byte writes

  assign wr_t34l[0] = sfr_req.wr && (sfr_req.addr == tmr_pkg::TIMER3_COUNT_LOW_ADDR);
  assign wr_t34h[0] = sfr_req.wr && (sfr_req.addr == tmr_pkg::TIMER3_COUNT_HIGH_ADDR);
  assign wr_t34l[1] = sfr_req.wr && (sfr_req.addr == tmr_pkg::TIMER4_COUNT_LOW_ADDR);
  assign wr_t34h[1] = sfr_req.wr && (sfr_req.addr == tmr_pkg::TIMER4_COUNT_HIGH_ADDR);

  // ----------------------------------------------------------------
  // Timers 0 and 1
  // ----------------------------------------------------------------
  logic [3:0] presc01_reg;    // Divide-by-12 prescaler
  logic [7:0] tl0_reg;        // Timer 0 low byte
  logic [7:0] th0_reg;        // Timer 0 high byte
  logic [7:0] tl1_reg;        // Timer 1 low byte
  logic [7:0] th1_reg;        // Timer 1 high byte
  wire        tick01;         // One clock in twelve
  wire        tl0_inc;        // Timer 0 low byte step
  wire        th0_inc;        // Timer 0 high byte step in split mode
  wire        tl1_inc;        // Timer 1 step
  wire        tl0_ovf;        // Timer 0 low byte wraps
  wire        th0_ovf;        // Timer 0 high byte wraps
  wire        tl1_ovf;        // Timer 1 wraps, feeds serial clocks
  logic [7:0] tl0_next;
  logic [7:0] th0_next;
  logic [7:0] tl1_next;

  assign tick01  = (presc01_reg == tmr_pkg::T01_TIMER_DIV - 4'h1);
  assign tl0_inc = t01_ctrl.t0_run && (t01_ctrl.t0_counter_select ? t0_pin_fall : tick01);
  // Split high byte is a timer under Timer 1's run control
  assign th0_inc = t01_ctrl.t0_split && t01_ctrl.t1_run && tick01;
  // Timer 1 runs freely in split mode since its run bit is lent out
  assign tl1_inc = (t01_ctrl.t0_split || t01_ctrl.t1_run)
                   && (t01_ctrl.t1_counter_select ? t1_pin_fall : tick01);
  assign tl0_ovf = tl0_inc && (tl0_reg == 8'hff);
  assign th0_ovf = th0_inc && (th0_reg == 8'hff);
  assign tl1_ovf = tl1_inc && (tl1_reg == 8'hff);

  // Next values; a write wins over counting
  always_comb
  begin
    tl0_next = tl0_reg;
    th0_next = th0_reg;
    tl1_next = tl1_reg;
    if (wr_tl0)
      tl0_next = sfr_req.wdata;
    else if (tl0_ovf)
      tl0_next = t01_ctrl.t0_split ? 8'h00 : th0_reg;
    else if (tl0_inc)
      tl0_next = tl0_reg + 8'h01;
    if (wr_th0)
      th0_next = sfr_req.wdata;
    else if (th0_inc)
      th0_next = th0_reg + 8'h01;
    if (wr_tl1)
      tl1_next = sfr_req.wdata;
    else if (tl1_ovf)
      tl1_next = th1_reg;
    else if (tl1_inc)
      tl1_next = tl1_reg + 8'h01;
  end

  // Timers 0/1 state
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      presc01_reg <= 4'h0;
      tl0_reg     <= tmr_pkg::BYTE_RESET;
      th0_reg     <= tmr_pkg::BYTE_RESET;
      tl1_reg     <= tmr_pkg::BYTE_RESET;
      th1_reg     <= tmr_pkg::BYTE_RESET;
    end
    else
    begin
      presc01_reg <= tick01 ? 4'h0 : presc01_reg + 4'h1;
      tl0_reg     <= tl0_next;
      th0_reg     <= th0_next;
      tl1_reg     <= tl1_next;
      th1_reg     <= wr_th1 ? sfr_req.wdata : th1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Timer 2
  // ----------------------------------------------------------------
  logic [7:0]  timer2_control_reg;      // Timer 2 control and flags
  logic [15:0] t2_cnt_reg;     // Timer 2 count
  logic [15:0] t2_rld_reg;     // Timer 2 reload/capture value
  logic [3:0]  presc2_reg;     // Timer 2 prescaler
  wire         baud_mode;      // Either serial clock select set
  wire         t2_tick;        // Timer 2 prescaler pulse
  wire         t2_inc;         // Timer 2 step
  wire         t2_ovf;         // Timer 2 wraps
  wire         t2_trig;        // Enabled trigger event
  wire         t2_capture;     // Capture the count
  wire         t2_edge_reload; // Reload on trigger
  wire         t2_ovf_reload;  // Reload on overflow
  wire [3:0]   t2_div;         // Active prescale count
  logic [7:0]  timer2_control_next;
  logic [15:0] t2_cnt_next;
  logic [15:0] t2_rld_next;

  assign baud_mode = timer2_control_reg[tmr_pkg::RX_CLOCK_SELECT_BIT] | timer2_control_reg[tmr_pkg::TX_CLOCK_SELECT_BIT];
  assign t2_div    = baud_mode ? tmr_pkg::T2_BAUD_DIV : tmr_pkg::T2_TIMER_DIV;
  assign t2_tick   = (presc2_reg >= t2_div - 4'h1);
  assign t2_inc    = timer2_control_reg[tmr_pkg::T2_RUN_BIT]
                     && (timer2_control_reg[tmr_pkg::T2_COUNTER_SELECT_BIT] ? t2_pin_fall : t2_tick);
  assign t2_ovf    = t2_inc && (t2_cnt_reg == 16'hffff);
  assign t2_trig   = timer2_control_reg[tmr_pkg::T2_TRIGGER_ENABLE_BIT] && t2_pin_fall;
  assign t2_capture     = t2_trig && !baud_mode && timer2_control_reg[tmr_pkg::T2_CAPTURE_SELECT_BIT];
  assign t2_edge_reload = t2_trig && !baud_mode && !timer2_control_reg[tmr_pkg::T2_CAPTURE_SELECT_BIT];
  assign t2_ovf_reload  = baud_mode || !timer2_control_reg[tmr_pkg::T2_CAPTURE_SELECT_BIT];

  // Control: write value, then hardware sets win over software clears
  always_comb
  begin
    timer2_control_next = wr_t2c ? sfr_req.wdata : timer2_control_reg;
    if (t2_ovf && !baud_mode)
      timer2_control_next[tmr_pkg::T2_OVERFLOW_FLAG_BIT] = 1'b1;
    if (t2_trig)
      timer2_control_next[tmr_pkg::T2_EDGE_FLAG_BIT] = 1'b1;
  end

  // Count: write, then trigger reload, then overflow, then step
  always_comb
  begin
    t2_cnt_next = t2_cnt_reg;
    if (wr_t2l || wr_t2h)
      t2_cnt_next = merge_byte(t2_cnt_reg, wr_t2h, sfr_req.wdata);
    else if (t2_edge_reload)
      t2_cnt_next = t2_rld_reg;
    else if (t2_ovf)
      t2_cnt_next = t2_ovf_reload ? t2_rld_reg : 16'h0000;
    else if (t2_inc)
      t2_cnt_next = t2_cnt_reg + 16'h0001;
  end

  // Reload/capture value: write or capture
  always_comb
  begin
    t2_rld_next = t2_rld_reg;
    if (wr_timer2_reload_low || wr_timer2_reload_high)
      t2_rld_next = merge_byte(t2_rld_reg, wr_timer2_reload_high, sfr_req.wdata);
    else if (t2_capture)
      t2_rld_next = t2_cnt_reg;
  end

  // Timer 2 state
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      timer2_control_reg  <= tmr_pkg::BYTE_RESET;
      t2_cnt_reg <= tmr_pkg::WORD_RESET;
      t2_rld_reg <= tmr_pkg::WORD_RESET;
      presc2_reg <= 4'h0;
    end
    else
    begin
      timer2_control_reg  <= timer2_control_next;
      t2_cnt_reg <= t2_cnt_next;
      t2_rld_reg <= t2_rld_next;
      presc2_reg <= t2_tick ? 4'h0 : presc2_reg + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Timers 3 and 4 (index 0 is Timer 3, index 1 is Timer 4)
  // ----------------------------------------------------------------
  logic [7:0]  timer3_4_control_reg;      // Control, modes and flags
  logic [15:0] t34_cnt_reg [2]; // Live counts
  logic [15:0] t34_rld_reg [2]; // Reload values
  logic [15:0] t34_cnt_next [2];
  logic [15:0] t34_rld_next [2];
  logic [7:0]  timer3_4_control_next;
  logic [1:0]  t34_run;         // Run bits
  logic [1:0]  t34_mode;        // Reload mode bits
  logic [1:0]  t34_ien;         // Interrupt enables
  logic [1:0]  t34_flag;        // Overflow flags
  logic [1:0]  t34_ovf;         // Overflow pulses

  // Field extraction, next counts and flags
  always_comb
  begin
    timer3_4_control_next = wr_t34c ? sfr_req.wdata : timer3_4_control_reg;
    for (int i = 0; i < 2; i++)
    begin
      t34_run[i]  = timer3_4_control_reg[i * tmr_pkg::T34_FIELD_STRIDE + tmr_pkg::T34_RUN_OFS];
      t34_mode[i] = timer3_4_control_reg[i * tmr_pkg::T34_FIELD_STRIDE + tmr_pkg::T34_RELOAD_MODE_OFS];
      t34_ien[i]  = timer3_4_control_reg[i * tmr_pkg::T34_FIELD_STRIDE + tmr_pkg::T34_IRQ_ENABLE_OFS];
      t34_flag[i] = timer3_4_control_reg[i * tmr_pkg::T34_FIELD_STRIDE + tmr_pkg::T34_OVERFLOW_OFS];
      t34_ovf[i]  = t34_run[i] && (t34_cnt_reg[i] == 16'hffff);
      t34_cnt_next[i] = t34_cnt_reg[i];
      t34_rld_next[i] = t34_rld_reg[i];
      if ((wr_t34l[i] || wr_t34h[i]) && t34_mode[i])
        t34_rld_next[i] = merge_byte(t34_rld_reg[i], wr_t34h[i], sfr_req.wdata);
      if ((wr_t34l[i] || wr_t34h[i]) && !t34_mode[i])
        t34_cnt_next[i] = merge_byte(t34_cnt_reg[i], wr_t34h[i], sfr_req.wdata);
      else if (t34_ovf[i])
        t34_cnt_next[i] = t34_mode[i] ? t34_rld_reg[i] : 16'h0000;
      else if (t34_run[i])
        t34_cnt_next[i] = t34_cnt_reg[i] + 16'h0001;
      // Flag set wins over a clearing write
      if (t34_ovf[i])
        timer3_4_control_next[i * tmr_pkg::T34_FIELD_STRIDE + tmr_pkg::T34_OVERFLOW_OFS] = 1'b1;
    end
  end

  // Timers 3/4 state
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      timer3_4_control_reg <= tmr_pkg::BYTE_RESET;
      for (int i = 0; i < 2; i++)
      begin
        t34_cnt_reg[i] <= tmr_pkg::WORD_RESET;
        t34_rld_reg[i] <= tmr_pkg::WORD_RESET;
      end
    end
    else
    begin
      timer3_4_control_reg <= timer3_4_control_next;
      for (int i = 0; i < 2; i++)
      begin
        t34_cnt_reg[i] <= t34_cnt_next[i];
        t34_rld_reg[i] <= t34_rld_next[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path, registered
  // ----------------------------------------------------------------
  logic [7:0] rd_mux; // Selected register, live counts for timers

  always_comb
  begin
    unique case (sfr_req.addr)
      tmr_pkg::TIMER0_COUNT_LOW_ADDR:   rd_mux = tl0_reg;
      tmr_pkg::TIMER1_COUNT_LOW_ADDR:   rd_mux = tl1_reg;
      tmr_pkg::TIMER0_COUNT_HIGH_ADDR:  rd_mux = th0_reg;
      tmr_pkg::TIMER1_COUNT_HIGH_ADDR:  rd_mux = th1_reg;
      tmr_pkg::TIMER4_COUNT_LOW_ADDR:   rd_mux = t34_cnt_reg[1][7:0];
      tmr_pkg::TIMER4_COUNT_HIGH_ADDR:  rd_mux = t34_cnt_reg[1][15:8];
      tmr_pkg::TIMER3_COUNT_LOW_ADDR:   rd_mux = t34_cnt_reg[0][7:0];
      tmr_pkg::TIMER3_COUNT_HIGH_ADDR:  rd_mux = t34_cnt_reg[0][15:8];
      tmr_pkg::TIMER2_CONTROL_ADDR:     rd_mux = timer2_control_reg;
      tmr_pkg::TIMER2_RELOAD_LOW_ADDR:  rd_mux = t2_rld_reg[7:0];
      tmr_pkg::TIMER2_RELOAD_HIGH_ADDR: rd_mux = t2_rld_reg[15:8];
      tmr_pkg::TIMER2_COUNT_LOW_ADDR:   rd_mux = t2_cnt_reg[7:0];
      tmr_pkg::TIMER2_COUNT_HIGH_ADDR:  rd_mux = t2_cnt_reg[15:8];
      tmr_pkg::TIMER3_4_CONTROL_ADDR:   rd_mux = timer3_4_control_reg;
      default:                          rd_mux = tmr_pkg::READ_UNMAPPED; // Unmapped offset
    endcase
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  wire t1_flag_src = t01_ctrl.t0_split ? th0_ovf : tl1_ovf;
  wire rx_src = timer2_control_reg[tmr_pkg::RX_CLOCK_SELECT_BIT] ? t2_ovf : tl1_ovf;
  wire tx_src = timer2_control_reg[tmr_pkg::TX_CLOCK_SELECT_BIT] ? t2_ovf : tl1_ovf;

  // Read data holds until the next read; pulses last one cycle
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      sfr_rdata      <= tmr_pkg::BYTE_RESET;
      t0_overflow    <= 1'b0;
      t1_overflow    <= 1'b0;
      rx_clock_pulse <= 1'b0;
      tx_clock_pulse <= 1'b0;
      t2_irq         <= 1'b0;
      t3_irq         <= 1'b0;
      t4_irq         <= 1'b0;
    end
    else
    begin
      sfr_rdata      <= sfr_req.rd ? rd_mux : sfr_rdata;
      t0_overflow    <= tl0_ovf;
      t1_overflow    <= t1_flag_src;
      rx_clock_pulse <= rx_src;
      tx_clock_pulse <= tx_src;
      t2_irq         <= timer2_control_reg[tmr_pkg::T2_OVERFLOW_FLAG_BIT] | timer2_control_reg[tmr_pkg::T2_EDGE_FLAG_BIT];
      t3_irq         <= t34_flag[0] & t34_ien[0];
      t4_irq         <= t34_flag[1] & t34_ien[1];
    end
  end

endmodule

/* testbench/tb.sv */
// Self-checking bench for the system timers
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; $display("unexpected %s %h %h", n, e, g); end end
module tb;
  logic                   mclk = 0;         // System clock
  logic                   nrst = 0;         // Reset, active low
  tmr_pkg::tmr_sfr_req_s  sfr_req = '0;     // Register access
  tmr_pkg::tmr_t01_ctrl_s t01_ctrl = '0;    // Timers 0/1 control
  logic                   t2_count_pin = 1; // Timer 2 pin
  logic [7:0]             sfr_rdata, la;    // Read data, byte address
  logic                   t0_overflow, t1_overflow, rx_clock_pulse, tx_clock_pulse, t2_irq, t3_irq, t4_irq;
  int                     num_errors = 0, compares = 0, n, sh;
  wire  logic [6:0]       outs = {t0_overflow, t1_overflow, rx_clock_pulse, tx_clock_pulse, t2_irq, t3_irq, t4_irq};
  logic [7:0] ra [14] = '{8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'hac, 8'had, 8'hae, 8'haf, 8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hcf};
  always #2 mclk = ~mclk;
  tmr_system_timers u_dut (.mclk, .nrst, .sfr_req, .sfr_rdata, .t01_ctrl, .t0_count_pin(1'b1), .t1_count_pin(1'b1),
    .t2_count_pin, .t0_overflow, .t1_overflow, .rx_clock_pulse, .tx_clock_pulse, .t2_irq, .t3_irq, .t4_irq);
  // Counts and verdict
  task results;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // One write cycle
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfr_req <= '{1'b1, 1'b0, a, d};
    @(posedge mclk);
    sfr_req.wr <= 1'b0;
  endtask
  // One read cycle, data checked a cycle later
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    sfr_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk);
    sfr_req.rd <= 1'b0;
    #1 `CHK("rdata", e, sfr_rdata)
  endtask
  // Bounded wait for one output bit
  task wt(input int k);
    n = 0;
    while (outs[k] !== 1'b1 && n < 1000)
    begin
      @(posedge mclk);
      #1 n++;
    end
    if (n == 1000)
    begin
      num_errors++;
      results;
    end
  endtask
  initial
  begin
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    foreach (ra[i]) rd(ra[i], 8'h00);
    rd(8'h00, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 2; i++)
    begin
      la = i ? 8'hac : 8'hae;
      sh = 4 * i;
      wr(la, 8'hf0);
      wr(la + 8'h01, 8'hff);
      wr(8'hcf, 8'h04 << sh);
      wr(la, 8'h00);
      wr(la + 8'h01, 8'h10);
      rd(la, 8'hf0);
      rd(la + 8'h01, 8'hff);
      wr(8'hcf, 8'h07 << sh);
      wt(i ? 0 : 1);
      rd(la + 8'h01, 8'h10);
      rd(8'hcf, 8'h0f << sh);
      wr(8'hcf, 8'h00);
      $display("test timer %0d done", 3 + i);
    end
    wr(8'h8c, 8'hf0);
    wr(8'h8a, 8'hfe);
    wr(8'h8d, 8'hff);
    t01_ctrl <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    wt(6);
    @(posedge mclk);
    #1 wt(6);
    `CHK("t0 gap", 191, n)
    rd(8'h8a, 8'hf0);
    $display("test timer 0 done");
    t01_ctrl <= '0;
    wr(8'hcd, 8'hab);
    wr(8'hcc, 8'hcd);
    wr(8'hc8, 8'h09);
    t2_count_pin <= 1'b0;
    repeat (6) @(posedge mclk);
    rd(8'hca, 8'hcd);
    rd(8'hcb, 8'hab);
    rd(8'hcc, 8'hcd);
    rd(8'hc8, 8'h49);
    wr(8'hc8, 8'h01);
    t2_count_pin <= 1'b1;
    wr(8'hcc, 8'h11);
    t2_count_pin <= 1'b0;
    repeat (6) @(posedge mclk);
    rd(8'hca, 8'hcd);
    rd(8'hc8, 8'h01);
    wr(8'hcb, 8'hff);
    wr(8'hca, 8'hfe);
    wr(8'hcd, 8'hff);
    wr(8'hc8, 8'h34);
    wt(4);
    `CHK("tx pulse", 1'b1, tx_clock_pulse)
    rd(8'hc8, 8'h34);
    wr(8'hc8, 8'h04);
    wt(2);
    rd(8'hc8, 8'h84);
    $display("test timer 2 done");
    results;
  end
endmodule

/* testbench/tmr_system_timers_checker.sv */
// Port-level assertions for the system timers
`timescale 1ns/1ps
module tmr_system_timers_checker
(
  input wire logic                   mclk,
  input wire logic                   nrst,
  input wire tmr_pkg::tmr_sfr_req_s  sfr_req,
  input wire tmr_pkg::tmr_t01_ctrl_s t01_ctrl,
  input wire logic                   t2_count_pin,
  input wire logic                   t0_overflow,
  input wire logic                   t1_overflow,
  input wire logic                   rx_clock_pulse,
  input wire logic                   tx_clock_pulse,
  input wire logic                   t2_irq,
  input wire logic                   t3_irq,
  input wire logic                   t4_irq
);
  logic [2:0] t2c_reg; // Selects and trigger enable as written
  logic [1:0] ien_reg; // Timer 4/3 irq enables as written
  wire  logic w2 = sfr_req.wr && sfr_req.addr == 8'hc8;
  wire  logic w34 = sfr_req.wr && sfr_req.addr == 8'hcf;
  wire  logic [2:0] t2c_next = w2 ? sfr_req.wdata[5:3] : t2c_reg;
  wire  logic [1:0] ien_next = w34 ? {sfr_req.wdata[4], sfr_req.wdata[0]} : ien_reg;
  // Shadow of control bits that only software changes
  always_ff @(posedge mclk)
  begin
    t2c_reg <= nrst ? t2c_next : 3'h0;
    ien_reg <= nrst ? ien_next : 2'h0;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_t3_irq_enable: assert property (t3_irq |-> $past(ien_reg[0])) else $error("t3 irq while disabled");
  a_t4_irq_enable: assert property (t4_irq |-> $past(ien_reg[1])) else $error("t4 irq while disabled");
  a_t0_tick_gap: assert property ($rose(t0_overflow) && !t01_ctrl.t0_counter_select |=> !t0_overflow [*8])
    else $error("t0 overflow too soon");
  a_t1_tick_gap: assert property (t1_overflow && !t01_ctrl.t1_counter_select |=> !t1_overflow [*8])
    else $error("t1 overflow too soon");
  a_rx_from_t1: assert property (!$past(t2c_reg[2]) && !$past(t01_ctrl.t0_split) |-> rx_clock_pulse == t1_overflow)
    else $error("rx pulse not from t1");
  a_tx_from_t1: assert property (!$past(t2c_reg[1]) && !$past(t01_ctrl.t0_split) |-> tx_clock_pulse == t1_overflow)
    else $error("tx pulse not from t1");
  a_both_from_t2: assert property ($past(t2c_reg[2:1]) == 2'h3 |-> rx_clock_pulse == tx_clock_pulse)
    else $error("rx and tx pulses differ");
  a_trigger_sets_flag: assert property (t2c_reg[0] && $fell(t2_count_pin) |-> ##[1:6] t2_irq)
    else $error("trigger edge without flag");
  c_t3_irq: cover property (t3_irq);
  c_baud: cover property (rx_clock_pulse && tx_clock_pulse);
  c_t0_ovf: cover property (t0_overflow);
endmodule
bind tmr_system_timers tmr_system_timers_checker u_chk (.mclk, .nrst, .sfr_req, .t01_ctrl, .t2_count_pin,
  .t0_overflow, .t1_overflow, .rx_clock_pulse, .tx_clock_pulse, .t2_irq, .t3_irq, .t4_irq);
